// file: shared/vst_map.vh
// Purpose: offsets, fields, reset values and positions of the stacking tagger
// Assumes: apb with 8-bit byte address, 32-bit data
// Notes:   definitions only
`ifndef VST_MAP_VH
`define VST_MAP_VH
////////////////////////////////////////////////////////////////////////////////
`define VST_CTRL       8'h00
`define VST_STATUS     8'h04
`define VST_COUNT      8'h08
`define VST_PSEL       8'h0c
`define VST_PCFG       8'h10
`define VST_TT0        8'h20
`define VST_TT1        8'h24
`define VST_TT2        8'h28
`define VST_TT3        8'h2c
////////////////////////////////////////////////////////////////////////////////
`define VST_F_ROLE     1:0
`define VST_F_TSEL     3:2
`define VST_F_PRI      6:4
`define VST_F_SVID     27:16
`define VST_ROLE_NORM  2'h0
`define VST_ROLE_ACC   2'h1
`define VST_ROLE_TUN   2'h2
`define VST_ROLE_BAD   2'h3
`define VST_PCFG_RST   28'h0010000
`define VST_CTRL_RST   2'h0
`define VST_TPID_STD   16'h8100
`define VST_NPORTS     5'h1a
`define VST_GIG_FIRST  5'h18
`define VST_SVID_MIN   12'h001
`define VST_SVID_MAX   12'hffe
////////////////////////////////////////////////////////////////////////////////
`define VST_TAG_LAST   11'h00b
`define VST_CHECK_POS  11'h010
`define VST_CRC_INIT   32'hffffffff
`define VST_CRC_POLY   32'hedb88320
`endif

// file: design/vst_crc32.v
// Purpose: one byte step of the ethernet crc, reflected form
// Assumes: lsb of each byte goes first on the wire
// Notes:   purely combinational
`timescale 1ns/1ps
`include "vst_map.vh"
module vst_crc32 (
    input  wire [31:0] crc_in,   // running remainder
    input  wire [7:0]  data,     // byte to fold in
    output wire [31:0] crc_out   // remainder after the byte
);
    function [31:0] crc_step;
        input [31:0] c;
        input [7:0]  d;
        integer i;
        reg [31:0] r;
        begin
            r = c ^ {24'h000000, d};
            for (i = 0; i < 8; i = i + 1) begin
                r = r[0] ? ((r >> 1) ^ `VST_CRC_POLY) : (r >> 1);
            end
            crc_step = r;
        end
    endfunction

    assign crc_out = crc_step(crc_in, data);
endmodule // vst_crc32

// file: design/vst_port_table.v
// Purpose: per-port stacking settings, one word per port
// Assumes: writer checks the word before it is written
// Notes:   two asynchronous read ports, frame side and bus side
`timescale 1ns/1ps
`include "vst_map.vh"
module vst_port_table (
    input  wire        pclk,     // clock
    input  wire        presetn,  // async reset, low
    input  wire        we,       // write strobe
    input  wire [4:0]  waddr,    // port written
    input  wire [27:0] wdata,    // checked settings word
    input  wire [4:0]  raddr_a,  // frame side port
    output wire [27:0] rdata_a,  // frame side settings
    input  wire [4:0]  raddr_b,  // bus side port
    output wire [27:0] rdata_b   // bus side settings
);
    reg [27:0] mem [0:25];
    integer i;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < 26; i = i + 1) begin
                mem[i] <= `VST_PCFG_RST;
            end
        end else if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // out-of-range ports read as reset settings, i.e. normal role
    assign rdata_a = (raddr_a < `VST_NPORTS) ? mem[raddr_a] : `VST_PCFG_RST;
    assign rdata_b = (raddr_b < `VST_NPORTS) ? mem[raddr_b] : `VST_PCFG_RST;
endmodule // vst_port_table

// file: design/vst_tagger.v
// Purpose: per-port vlan stacking on the byte stream between ports and fabric
// Assumes: frames of at least 18 bytes, fcs included, one byte per cycle
// Notes:   port settings are taken at the first byte and hold for the whole frame; strip and retype match against the live type slots
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "vst_map.vh"
module vst_tagger (
    input  wire        pclk,                  // clock, 40 MHz
    input  wire        presetn,               // async reset, low
    input  wire        psel,                  // apb select
    input  wire        penable,               // apb enable
    input  wire        pwrite,                // apb write
    input  wire [7:0]  paddr,                 // apb byte address
    input  wire [31:0] pwdata,                // apb write data
    output reg  [31:0] prdata,                // apb read data
    output reg         pready,                // apb ready
    output reg         pslverr,               // apb error, unmapped
    input  wire        in_valid,              // input byte valid
    input  wire [7:0]  in_data,               // input byte
    input  wire        in_sof,                // first byte of frame
    input  wire        in_eof,                // last byte of frame
    input  wire [4:0]  in_port,               // port index of frame
    input  wire        in_egress,             // 1 fabric to port, 0 port to fabric
    output reg         in_ready,              // input byte taken
    output reg         out_valid,             // output byte valid
    output reg  [7:0]  out_data,              // output byte
    output reg         out_sof,               // first output byte
    output reg         out_eof,               // last output byte
    output reg         out_double_tag,        // outer tag seen on tunnel ingress
    output reg  [11:0] out_outer_vlan_number  // outer vlan id seen
);
    localparam ST_RUN  = 3'b001;
    localparam ST_INS  = 3'b010;
    localparam ST_TAIL = 3'b100;
    localparam OP_PASS = 3'h0;
    localparam OP_INS  = 3'h1;
    localparam OP_CHK  = 3'h2;
    localparam OP_RETY = 3'h3;
    localparam OP_STRP = 3'h4;

    function [15:0] tt_pick;
        input [1:0]  s;
        input [63:0] all;
        begin
            tt_pick = all[{s, 4'h0} +: 16];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // configuration, status and count registers
    reg  [1:0]  ctrl;
    reg  [4:0]  pidx;
    reg         refused;
    reg  [15:0] tt0;
    reg  [15:0] tt1;
    reg  [15:0] tt2;
    reg  [15:0] tt3;
    reg  [15:0] ins_cnt;
    reg  [15:0] strip_cnt;
    reg         fbusy;
    wire [63:0] tt_all = {tt3, tt2, tt1, tt0};
    wire [27:0] cfg_f;
    wire [27:0] cfg_a;

    ////////////////////////////////////////////////////////////////////////////
    // apb slave, no wait state: answer is registered from the setup cycle
    wire        apb_setup = psel & ~penable;
    wire        apb_wr    = psel & penable & pready & pwrite & ~pslverr;
    wire [1:0]  w_role    = pwdata[`VST_F_ROLE];
    wire [1:0]  w_tsel    = pwdata[`VST_F_TSEL];
    wire [2:0]  w_pri     = pwdata[`VST_F_PRI];
    wire [11:0] w_svid    = pwdata[`VST_F_SVID];
    wire        ctrl_ok   = ~(pwdata[0] & pwdata[1]);
    wire        pcfg_ok   = (w_role != `VST_ROLE_BAD) && (pidx < `VST_NPORTS) &&
                            !(w_role == `VST_ROLE_TUN && pidx < `VST_GIG_FIRST) &&
                            (w_svid >= `VST_SVID_MIN) && (w_svid <= `VST_SVID_MAX);
    wire        pcfg_we   = apb_wr & (paddr == `VST_PCFG) & pcfg_ok;
    wire [27:0] pcfg_word = {w_svid, 9'h000, w_pri, w_tsel, w_role};
    reg  [31:0] rd;
    reg         hit;

    always @* begin
        rd  = 32'h00000000;
        hit = 1'b1;
        case (paddr)
            `VST_CTRL:   rd = {30'h00000000, ctrl};
            `VST_STATUS: rd = {30'h00000000, fbusy, refused};
            `VST_COUNT:  rd = {ins_cnt, strip_cnt};
            `VST_PSEL:   rd = {27'h0000000, pidx};
            `VST_PCFG:   rd = {4'h0, cfg_a};
            `VST_TT0,
            `VST_TT1,
            `VST_TT2,
            `VST_TT3:    rd = {16'h0000, tt_pick(paddr[3:2], tt_all)};
            default:     hit = 1'b0;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            ctrl    <= `VST_CTRL_RST;
            pidx    <= 5'h00;
            refused <= 1'b0;
            tt0     <= `VST_TPID_STD;
            tt1     <= `VST_TPID_STD;
            tt2     <= `VST_TPID_STD;
            tt3     <= `VST_TPID_STD;
        end else begin
            pready  <= apb_setup;
            pslverr <= apb_setup & ~hit;
            prdata  <= (apb_setup & ~pwrite) ? rd : 32'h00000000;
            if (apb_wr) begin
                refused <= 1'b0;
                case (paddr)
                    `VST_CTRL: begin
                        if (ctrl_ok) begin
                            ctrl <= pwdata[1:0];
                        end else begin
                            refused <= 1'b1;
                        end
                    end
                    `VST_PSEL: pidx <= pwdata[4:0];
                    `VST_PCFG: refused <= ~pcfg_ok;
                    // only four type slots exist, so no more can be in use
                    `VST_TT0: tt0 <= pwdata[15:0];
                    `VST_TT1: tt1 <= pwdata[15:0];
                    `VST_TT2: tt2 <= pwdata[15:0];
                    `VST_TT3: tt3 <= pwdata[15:0];
                    default: refused <= 1'b0;
                endcase
            end
        end
    end

    vst_port_table u_table (
        .pclk    (pclk),
        .presetn (presetn),
        .we      (pcfg_we),
        .waddr   (pidx),
        .wdata   (pcfg_word),
        .raddr_a (in_port),
        .rdata_a (cfg_f),
        .raddr_b (pidx),
        .rdata_b (cfg_a)
    );

    ////////////////////////////////////////////////////////////////////////////
    // frame engine: a four byte window delays the stream so that the old fcs
    // can be dropped and the outer tag edited in place once bytes 12..15 sit in it
    reg  [2:0]  state;
    reg  [2:0]  op;
    reg  [15:0] ftype;
    reg  [2:0]  fpri;
    reg  [11:0] fsvid;
    reg         fmod;
    reg  [10:0] cnt;
    reg  [31:0] win;
    reg  [2:0]  wcnt;
    reg  [1:0]  ik;
    reg  [1:0]  tk;
    reg         osof;
    reg  [31:0] crc;
    wire [31:0] crc_nx;
    reg  [2:0]  next_op;

    wire [1:0]  f_role   = cfg_f[`VST_F_ROLE];
    wire        take     = in_valid & in_ready & (state == ST_RUN) & (fbusy | in_sof);
    wire        chk      = take & ~in_sof & (cnt == `VST_CHECK_POS) & (wcnt == 3'h4);
    wire [15:0] wtype    = win[31:16];
    wire        any_m    = (wtype == tt0) | (wtype == tt1) | (wtype == tt2) | (wtype == tt3);
    wire        do_strip = chk & (op == OP_STRP) & any_m;
    wire        do_rety  = chk & (op == OP_RETY) & any_m;
    wire [31:0] wmod     = do_rety ? {ftype, win[15:0]} : win;
    wire [31:0] tagw     = {ftype, fpri, 1'b0, fsvid};
    wire        push     = take | (state == ST_INS);
    wire [7:0]  pbyte    = (state == ST_INS) ? tagw[{~ik, 3'h0} +: 8] : in_data;
    wire        emit     = push & (wcnt == 3'h4) & ~do_strip;
    wire [31:0] crc_fin  = ~crc;

    always @* begin
        next_op = OP_PASS;
        if (!ctrl[0] || f_role == `VST_ROLE_NORM) begin
            next_op = OP_PASS;
        end else if (!in_egress) begin
            next_op = (f_role == `VST_ROLE_ACC) ? OP_INS : OP_CHK;
        end else begin
            next_op = (f_role == `VST_ROLE_ACC) ? OP_STRP : OP_RETY;
        end
    end

    vst_crc32 u_crc (
        .crc_in  (crc),
        .data    (wmod[31:24]),
        .crc_out (crc_nx)
    );

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state                 <= ST_RUN;
            in_ready              <= 1'b0;
            out_valid             <= 1'b0;
            out_data              <= 8'h00;
            out_sof               <= 1'b0;
            out_eof               <= 1'b0;
            out_double_tag        <= 1'b0;
            out_outer_vlan_number <= 12'h000;
            op                    <= OP_PASS;
            ftype                 <= `VST_TPID_STD;
            fpri                  <= 3'h0;
            fsvid                 <= `VST_SVID_MIN;
            fmod                  <= 1'b0;
            cnt                   <= 11'h000;
            win                   <= 32'h00000000;
            wcnt                  <= 3'h0;
            ik                    <= 2'h0;
            tk                    <= 2'h0;
            osof                  <= 1'b0;
            crc                   <= `VST_CRC_INIT;
            fbusy                 <= 1'b0;
            ins_cnt               <= 16'h0000;
            strip_cnt             <= 16'h0000;
        end else begin
            out_valid <= 1'b0;
            out_sof   <= 1'b0;
            out_eof   <= 1'b0;
            case (state)
                ST_RUN: begin
                    in_ready <= 1'b1;
                    if (take) begin
                        if (in_sof) begin
                            op                    <= next_op;
                            ftype                 <= tt_pick(cfg_f[`VST_F_TSEL], tt_all);
                            fpri                  <= cfg_f[`VST_F_PRI];
                            fsvid                 <= cfg_f[`VST_F_SVID];
                            fmod                  <= (next_op == OP_INS);
                            cnt                   <= 11'h001;
                            osof                  <= 1'b1;
                            crc                   <= `VST_CRC_INIT;
                            fbusy                 <= 1'b1;
                            out_double_tag        <= 1'b0;
                            out_outer_vlan_number <= 12'h000;
                        end else begin
                            cnt <= cnt + 11'h001;
                        end
                        if (do_strip | do_rety) begin
                            fmod <= 1'b1;
                        end
                        if (do_strip) begin
                            strip_cnt <= strip_cnt + 16'h0001;
                        end
                        if (chk && op == OP_CHK && wtype == ftype) begin
                            out_double_tag        <= 1'b1;
                            out_outer_vlan_number <= win[11:0];
                        end
                        if (in_eof) begin
                            state    <= ST_TAIL;
                            in_ready <= 1'b0;
                            tk       <= 2'h0;
                        end else if (!in_sof && cnt == `VST_TAG_LAST && op == OP_INS) begin
                            state    <= ST_INS;
                            in_ready <= 1'b0;
                            ik       <= 2'h0;
                        end
                    end
                end
                ST_INS: begin
                    ik <= ik + 2'h1;
                    if (ik == 2'h3) begin
                        state    <= ST_RUN;
                        in_ready <= 1'b1;
                        ins_cnt  <= ins_cnt + 16'h0001;
                    end
                end
                ST_TAIL: begin
                    // unmodified frames keep their own fcs bytes
                    out_valid <= 1'b1;
                    out_data  <= fmod ? crc_fin[{tk, 3'h0} +: 8] : win[31:24];
                    win       <= {win[23:0], 8'h00};
                    tk        <= tk + 2'h1;
                    if (tk == 2'h3) begin
                        out_eof  <= 1'b1;
                        state    <= ST_RUN;
                        in_ready <= 1'b1;
                        wcnt     <= 3'h0;
                        fbusy    <= 1'b0;
                    end
                end
                default: begin
                    state    <= ST_RUN;
                    in_ready <= 1'b1;
                end
            endcase
            if (push) begin
                // a matched outer tag in the window is simply thrown away
                win  <= do_strip ? {24'h000000, pbyte} : {wmod[23:0], pbyte};
                wcnt <= do_strip ? 3'h1 : ((wcnt == 3'h4) ? 3'h4 : wcnt + 3'h1);
            end
            if (emit) begin
                out_valid <= 1'b1;
                out_data  <= wmod[31:24];
                out_sof   <= osof;
                osof      <= 1'b0;
                crc       <= crc_nx;
            end
        end
    end
endmodule // vst_tagger

// file: testbench/vst_tagger_properties.sv
// Purpose: port-level timing checks for the stacking tagger
// Assumes: sees only the top module's ports
// Notes:   bound from the bench top file
`timescale 1ns/1ps
module vst_tagger_properties (
    input wire        pclk,      // clock
    input wire        presetn,   // async reset, low
    input wire        psel,      // apb select
    input wire        penable,   // apb enable
    input wire [7:0]  paddr,     // apb address
    input wire [31:0] prdata,    // apb read data
    input wire        pready,    // apb ready
    input wire        pslverr,   // apb error
    input wire        in_valid,  // byte offered
    input wire        in_sof,    // first byte in
    input wire        in_eof,    // last byte in
    input wire        in_ready,  // byte taken
    input wire        out_valid, // byte out
    input wire        out_sof,   // first byte out
    input wire        out_eof    // last byte out
);
////////////////////////////////////////
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
wire take_eof = in_valid && in_ready && in_eof;

AST_PREADY_SETUP: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
AST_PREADY_ONLY: assert property (!(psel && !penable) |=> !pready)
    else $error("ready without setup");
AST_SLVERR_MAP: assert property (pready |-> pslverr ==
    !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20, 8'h24, 8'h28, 8'h2c}))
    else $error("error flag disagrees with map");
AST_PRDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
AST_TAIL_HOLD: assert property (take_eof |=> !in_ready [*4] ##1 in_ready)
    else $error("tail stall length wrong");
AST_EOF_LAG: assert property (take_eof |-> ##5 out_eof)
    else $error("last byte out late");
AST_SOF_LAG: assert property (in_valid && in_ready && in_sof |-> ##5 out_sof)
    else $error("first byte out late");
AST_EOF_ALONE: assert property (out_eof |-> out_valid && !out_sof)
    else $error("bad frame end marks");
endmodule // vst_tagger_properties

// file: testbench/vst_frame_sink.sv
// Purpose: port side model collecting each outgoing frame
// Assumes: one byte per out_valid, no stall
// Notes:   done rises after the last byte
`timescale 1ns/1ps
module vst_frame_sink (
    input wire       pclk,      // clock
    input wire       presetn,   // async reset, low
    input wire       out_valid, // byte strobe
    input wire [7:0] out_data,  // byte
    input wire       out_sof,   // first byte
    input wire       out_eof    // last byte
);
////////////////////////////////////////
logic [7:0] q[$];
logic       done;
// a port has no way to push back, so every byte is taken at once
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        done <= 1'b0;
    end else if (out_valid) begin
        if (out_sof)
            q.delete();
        q.push_back(out_data);
        done <= out_eof;
    end
end
endmodule // vst_frame_sink

// file: testbench/tb_vst_tagger.sv
// Purpose: register and frame tests of the stacking tagger
// Assumes: apb answers in one access cycle, 4+1 byte lag
// Notes:   expected fcs worked out here
`timescale 1ns/1ps
module tb_vst_tagger;
logic        pclk, presetn, psel, penable, pwrite, in_valid, in_sof, in_eof, in_egress;
logic [7:0]  paddr, in_data;
logic [31:0] pwdata, rd;
logic [4:0]  in_port;
logic        er;
wire  [31:0] prdata;
wire         pready, pslverr, in_ready, out_valid, out_sof, out_eof, out_double_tag;
wire  [7:0]  out_data;
wire  [11:0] out_outer_vlan_number;
int          fails = 0, num_checks = 0, cyc = 0, k;
logic [7:0]  fr[$], ex[$];
logic [31:0] bad[4] = '{32'h00000002, 32'h00000001, 32'h0fff0001, 32'h00010003};
////////////////////////////////////////
vst_tagger dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_valid(in_valid), .in_data(in_data), .in_sof(in_sof),
    .in_eof(in_eof), .in_port(in_port), .in_egress(in_egress), .in_ready(in_ready),
    .out_valid(out_valid), .out_data(out_data), .out_sof(out_sof), .out_eof(out_eof),
    .out_double_tag(out_double_tag), .out_outer_vlan_number(out_outer_vlan_number));
vst_frame_sink snk (.pclk(pclk), .presetn(presetn), .out_valid(out_valid),
    .out_data(out_data), .out_sof(out_sof), .out_eof(out_eof));
initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
end
always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
        fails++;
        complete_run;
    end
end
task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
endtask
task automatic chk(input string nm, input [31:0] e, input [31:0] g);
    num_checks++;
    if (g !== e) begin
        fails++;
        $display("ERROR %s expected %h seen %h", nm, e, g);
    end
endtask
task automatic chk_frame(input string nm);
    int i, b;
    b = -1;
    for (i = 0; i < ex.size(); i++)
        if (b < 0 && snk.q[i] !== ex[i])
            b = i;
    chk({nm, " length"}, ex.size(), snk.q.size());
    chk({nm, " first bad byte"}, 32'hffffffff, b);
endtask
// waits have no local limit: only the cycle ceiling ends a hang
task automatic apb(input w, input [7:0] a, input [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
        @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge so a following call never drives psel twice in one step
    @(posedge pclk);
endtask
task automatic run(input [4:0] p, input e);
    int i;
    for (i = 0; i < fr.size(); i++) begin
        in_valid <= 1'b1;
        in_data <= fr[i];
        in_sof <= (i == 0);
        in_eof <= (i == fr.size() - 1);
        in_port <= p;
        in_egress <= e;
        @(posedge pclk);
        while (in_ready !== 1'b1)
            @(posedge pclk);
    end
    in_valid <= 1'b0;
    in_sof <= 1'b0;
    in_eof <= 1'b0;
    while (snk.done !== 1'b1)
        @(posedge pclk);
endtask
task automatic mk;
    int i;
    fr = {};
    for (i = 0; i < 24; i++)
        fr.push_back(8'(i * 29 + 1));
endtask
// fcs goes lsb byte first, complemented remainder
task automatic add_fcs;
    logic [31:0] c;
    int i, b;
    c = 32'hffffffff;
    for (i = 0; i < ex.size(); i++) begin
        c ^= {24'h0, ex[i]};
        for (b = 0; b < 8; b++)
            c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
    end
    for (b = 0; b < 4; b++)
        ex.push_back(~c[8*b +: 8]);
endtask
initial begin
    {psel, penable, pwrite, in_valid, in_sof, in_eof, in_egress} = '0;
    paddr = '0;
    pwdata = '0;
    in_data = '0;
    in_port = '0;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, 8'h00, 0);
    chk("ctrl reset", 32'h0, rd);
    apb(0, 8'h10, 0);
    chk("port cfg reset", 32'h00010000, rd);
    for (k = 0; k < 4; k++) begin
        apb(0, 8'h20 + 8'(4 * k), 0);
        chk("type slot reset", 32'h8100, rd);
    end
    apb(0, 8'h40, 0);
    chk("unmapped error", 1, er);
    apb(1, 8'h00, 32'h3);
    apb(0, 8'h04, 0);
    chk("map with stacking refused", 1, rd[0]);
    apb(0, 8'h00, 0);
    chk("ctrl kept", 0, rd);
    apb(1, 8'h0c, 3);
    foreach (bad[i]) begin
        apb(1, 8'h10, bad[i]);
        apb(0, 8'h04, 0);
        chk("bad port cfg refused", 1, rd[0]);
    end
    apb(1, 8'h2c, 32'hffff);
    apb(0, 8'h2c, 0);
    chk("type slot full range", 32'hffff, rd);
    apb(1, 8'h24, 32'h9100);
    // software keeps transmit tagging off on this port
    apb(1, 8'h10, 32'h0ffe0075);
    apb(0, 8'h04, 0);
    chk("good cfg accepted", 0, rd[0]);
    apb(0, 8'h10, 0);
    chk("cfg readback", 32'h0ffe0075, rd);
    mk;
    ex = fr;
    run(3, 0);
    chk_frame("inactive pass");
    apb(1, 8'h00, 1);
    run(3, 0);
    ex = {fr[0:11], 8'h91, 8'h00, 8'hef, 8'hfe, fr[12:$-4]};
    add_fcs;
    chk_frame("access insert");
    ex = fr;
    run(5, 0);
    chk_frame("normal pass");
    fr[12] = 8'h91;
    fr[13] = 8'h00;
    run(3, 1);
    ex = {fr[0:11], fr[16:$-4]};
    add_fcs;
    chk_frame("access strip");
    apb(0, 8'h08, 0);
    chk("insert and strip counts", 32'h00010001, rd);
    apb(1, 8'h0c, 24);
    // software sets transmit tagging on this port
    apb(1, 8'h10, 32'h00250006);
    fr[14] = 8'ha0;
    fr[15] = 8'h25;
    ex = fr;
    run(24, 0);
    chk_frame("tunnel ingress pass");
    chk("double tag seen", 1, out_double_tag);
    chk("outer vlan number", 32'h025, out_outer_vlan_number);
    fr[12] = 8'h81;
    run(24, 1);
    ex = fr[0:$-4];
    ex[12] = 8'h91;
    add_fcs;
    chk_frame("tunnel egress type");
    chk("double tag cleared", 0, out_double_tag);
    complete_run;
end
endmodule // tb_vst_tagger
bind vst_tagger vst_tagger_properties u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_valid(in_valid), .in_sof(in_sof), .in_eof(in_eof),
    .in_ready(in_ready), .out_valid(out_valid), .out_sof(out_sof), .out_eof(out_eof));
